// >>> src/pfs_top.sv
`timescale 1ns/100ps
`default_nettype none
module pfs_top #(
   parameter int NPAD   = pfs_pkg::PFS_NPAD,
   parameter int NINSEL = pfs_pkg::PFS_NINSEL
) (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rstn,
   input  wire logic [pfs_pkg::PFS_ADDR_W-1:0]        addr,
   input  wire logic [pfs_pkg::PFS_DATA_W-1:0]        wdata,
   input  wire logic                                  wr_en,
   input  wire logic                                  rd_en,
   output logic      [pfs_pkg::PFS_DATA_W-1:0]        rdata,
   input  wire logic [NPAD-1:0]                       pad_in,
   output logic      [NPAD-1:0]                       pad_out,
   output logic      [NPAD-1:0]                       pad_oe,
   output logic      [NPAD-1:0]                       pad_pu,
   input  wire pfs_pkg::pfs_drv_t [NPAD-1:0][3:0]     periph_drv,
   output logic      [NPAD-1:0]                       periph_pad_in,
   output logic      [NINSEL-1:0]                     insel_in,
   output logic      [1:0]                            nmi_in,
   input  wire logic                                  tap_tdo,
   input  wire logic                                  tap_tdo_oe,
   output logic                                       tap_tdi,
   output logic                                       tap_tck,
   output logic                                       tap_tms,
   input  wire pfs_pkg::pfs_dbg_t                     dbg_ctrl,
   input  wire pfs_pkg::pfs_trace_t                   trace,
   input  wire logic                                  selftest_en
);
   import pfs_pkg::*;

   localparam int DW = PFS_DATA_W;
   localparam int AW = PFS_ADDR_W;

   initial begin
      if (NPAD < PFS_PAD_GPO + PFS_NGPO || NPAD > DW) begin
         $error("pad count out of range");
      end
      if (NINSEL < 1 || NINSEL > 16) begin
         $error("input select count out of range");
      end
   end

   pfs_pcr_t              pcr_r [NPAD];
   logic [NPAD-1:0]       dout_r;
   logic [3:0]            own_r;
   logic [PFS_SEL_W-1:0]  insel_r [NINSEL];
   logic [NPAD-1:0]       in_s1_r;
   logic [NPAD-1:0]       in_s2_r;
   logic                  rst_phase_r;
   logic [DW-1:0]         rd_nxt;
   logic [NPAD-1:0]       cell_out;
   logic [NPAD-1:0]       cell_oe;
   logic [NPAD-1:0]       ibe_vec;
   logic [NPAD-1:0]       nmi0_vec;
   logic [NPAD-1:0]       nmi1_vec;
   logic [NPAD-1:0]       gpio_only;
   logic                  trc_lo_en;
   logic                  trc_hi_en;
   logic                  bist_drive;

   // pcr writes and per-pad mux cells
   genvar gi;
   generate
      for (gi = 0; gi < NPAD; gi++) begin : g_pad
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               pcr_r[gi] <= pfs_pcr_t'(PFS_PCR_RST);
            end else if (wr_en && addr == AW'(PFS_PCR_BASE + 4 * gi)) begin
               pcr_r[gi] <= pfs_pcr_t'(wdata[7:0]);
            end
         end

         assign ibe_vec[gi]   = pcr_r[gi].input_buffer_enable;
         assign nmi0_vec[gi]  = pcr_r[gi].nmi0_sel;
         assign nmi1_vec[gi]  = pcr_r[gi].nmi1_sel;
         assign gpio_only[gi] = (gi >= PFS_PAD_GPO) && (gi < PFS_PAD_GPO + PFS_NGPO);

         pfs_pad_cell u_cell (
            .cfg       (pcr_r[gi]),
            .gpio_only (gpio_only[gi]),
            .gpio_data (dout_r[gi]),
            .alt       (periph_drv[gi]),
            .out       (cell_out[gi]),
            .oe        (cell_oe[gi])
         );
      end

      for (gi = 0; gi < NINSEL; gi++) begin : g_insel
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               insel_r[gi] <= PFS_INSEL_RST;
            end else if (wr_en && addr == AW'(PFS_INSEL_BASE + 4 * gi)) begin
               insel_r[gi] <= wdata[PFS_SEL_W-1:0];
            end
         end

         always_comb begin
            insel_in[gi] = 1'b0;
            if (int'(insel_r[gi]) < NPAD) begin
               insel_in[gi] = periph_pad_in[insel_r[gi]];
            end
         end
      end
   endgenerate

   // gpio data out register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dout_r <= '0;
      end else if (wr_en && addr == PFS_DOUT_ADDR) begin
         dout_r <= wdata[NPAD-1:0];
      end
   end

   // test-port ownership, software clears to hand pads to gpio
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         own_r <= PFS_OWN_RST;
      end else if (wr_en && addr == PFS_OWN_ADDR) begin
         own_r <= wdata[3:0];
      end
   end

   // first cycle after reset release
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_phase_r <= 1'b1;
      end else begin
         rst_phase_r <= 1'b0;
      end
   end

   // pad input synchroniser
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         in_s1_r <= '0;
         in_s2_r <= '0;
      end else begin
         in_s1_r <= pad_in;
         in_s2_r <= in_s1_r;
      end
   end

   // input fan-out, gated by input buffer enable only
   assign periph_pad_in = in_s2_r & ibe_vec;

   // nmi inputs take the pad whatever its function code
   assign nmi_in[0] = |(in_s2_r & nmi0_vec);
   assign nmi_in[1] = |(in_s2_r & nmi1_vec);

   // test-port inputs while owned
   assign tap_tdi = own_r[PFS_PAD_TDI] & in_s2_r[PFS_PAD_TDI];
   assign tap_tck = own_r[PFS_PAD_TCK] & in_s2_r[PFS_PAD_TCK];
   assign tap_tms = own_r[PFS_PAD_TMS] & in_s2_r[PFS_PAD_TMS];

   // debugger trace claim
   assign trc_lo_en = dbg_ctrl.trace_clock_enable | dbg_ctrl.pipeline_status_enable;
   assign trc_hi_en = (dbg_ctrl.trace_clock_enable & dbg_ctrl.full_port_mode)
                    | dbg_ctrl.pipeline_status_enable;

   // self-test indication while reset is applied
   assign bist_drive = selftest_en & ~rstn;

   // pad output arbitration
   always_comb begin
      for (int i = 0; i < NPAD; i++) begin
         pad_out[i] = cell_out[i];
         pad_oe[i]  = cell_oe[i];
         pad_pu[i]  = pcr_r[i].pull_up_enable;
         if (pcr_r[i].nmi0_sel || pcr_r[i].nmi1_sel) begin
            pad_out[i] = 1'b0;
            pad_oe[i]  = 1'b0;
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (own_r[i]) begin
            pad_out[i] = 1'b0;
            pad_oe[i]  = 1'b0;
         end
      end
      if (own_r[PFS_PAD_TDO]) begin
         pad_out[PFS_PAD_TDO] = tap_tdo;
         pad_oe[PFS_PAD_TDO]  = tap_tdo_oe;
      end
      for (int i = 0; i < PFS_NTRC; i++) begin
         if ((i < PFS_NTRC_LO) ? trc_lo_en : trc_hi_en) begin
            pad_out[PFS_PAD_TRC + i] = trace.trace_data_out[i];
            pad_oe[PFS_PAD_TRC + i]  = 1'b1;
         end
      end
      if (trc_lo_en) begin
         pad_out[PFS_PAD_MSG]  = trace.trace_msg_start_end;
         pad_oe[PFS_PAD_MSG]   = 1'b1;
         pad_out[PFS_PAD_TCLK] = trace.trace_clock_out;
         pad_oe[PFS_PAD_TCLK]  = 1'b1;
      end
      if (bist_drive) begin
         pad_out[PFS_PAD_TRC] = 1'b1;
         pad_oe[PFS_PAD_TRC]  = 1'b1;
         pad_pu[PFS_PAD_TRC]  = 1'b0;
      end
   end

   // read data mux, unmapped reads return zero
   always_comb begin
      rd_nxt = '0;
      for (int i = 0; i < NPAD; i++) begin
         if (addr == AW'(PFS_PCR_BASE + 4 * i)) begin
            rd_nxt = DW'(pcr_r[i]);
         end
      end
      for (int i = 0; i < NINSEL; i++) begin
         if (addr == AW'(PFS_INSEL_BASE + 4 * i)) begin
            rd_nxt = DW'(insel_r[i]);
         end
      end
      if (addr == PFS_DOUT_ADDR) begin
         rd_nxt = DW'(dout_r);
      end
      if (addr == PFS_DIN_ADDR) begin
         rd_nxt = DW'(periph_pad_in);
      end
      if (addr == PFS_OWN_ADDR) begin
         rd_nxt = DW'(own_r);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (rd_en) begin
         rdata <= rd_nxt;
      end else begin
         rdata <= '0;
      end
   end

   // checks on a plain general pad
   localparam int CK = PFS_PAD_GPO + PFS_NGPO;

   generate
      if (NPAD > CK) begin : g_chk
         alt_code_decode_a : assert property (@(posedge clk_sys) disable iff (!rstn)
            (pcr_r[CK].alt_func_select == 3'h2 && !pcr_r[CK].nmi0_sel
             && !pcr_r[CK].nmi1_sel)
            |-> (pad_oe[CK] == periph_drv[CK][1].oe && pad_out[CK] == periph_drv[CK][1].data))
            else $error("code 010 did not route the third function");

         unused_code_off_a : assert property (@(posedge clk_sys) disable iff (!rstn)
            (pcr_r[CK].alt_func_select > 3'h4) |-> !pad_oe[CK])
            else $error("unused code left the pad driven");

         input_gate_a : assert property (@(posedge clk_sys) disable iff (!rstn)
            (!pcr_r[CK].input_buffer_enable && $past(in_s1_r[CK])) |-> !periph_pad_in[CK])
            else $error("input passed with buffer disabled");

         nmi_prio_a : assert property (@(posedge clk_sys) disable iff (!rstn)
            (pcr_r[CK].nmi0_sel && $past(pad_in[CK], 2) && $past(rstn, 2))
            |-> (!pad_oe[CK] && nmi_in[0]))
            else $error("nmi pad not taken over");
      end
   endgenerate

   reset_gpio_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      rst_phase_r |-> (pcr_r[0] == pfs_pcr_t'(PFS_PCR_RST) && pcr_r[PFS_PAD_GPO] ==
                       pfs_pcr_t'(PFS_PCR_RST) && !pad_oe[PFS_PAD_GPO]))
      else $error("pad not general i/o after reset");

   tap_own_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (rst_phase_r && tap_tdo_oe && !trc_lo_en)
      |-> (pad_oe[PFS_PAD_TDO] && pad_out[PFS_PAD_TDO] == tap_tdo))
      else $error("test port data out missing after reset");

   trace_lo_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (dbg_ctrl.trace_clock_enable || dbg_ctrl.pipeline_status_enable)
      |-> (pad_oe[PFS_PAD_TRC + 7] && pad_oe[PFS_PAD_MSG] && pad_oe[PFS_PAD_TCLK]
           && pad_out[PFS_PAD_TCLK] == trace.trace_clock_out))
      else $error("low trace outputs not enabled");

   trace_hi_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (dbg_ctrl.trace_clock_enable && !dbg_ctrl.full_port_mode
       && !dbg_ctrl.pipeline_status_enable && pcr_r[PFS_PAD_TRC + 8] ==
       pfs_pcr_t'(PFS_PCR_RST))
      |-> !pad_oe[PFS_PAD_TRC + 8])
      else $error("high trace outputs enabled without full port");

   // second nmi input on the last pad
   nmi1_prio_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (pcr_r[NPAD-1].nmi1_sel && $past(pad_in[NPAD-1], 2) && $past(rstn, 2))
      |-> (!pad_oe[NPAD-1] && nmi_in[1]))
      else $error("second nmi pad not taken over");

   // gpio-only pad never driven by a peripheral code
   gpio_only_off_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (pcr_r[PFS_PAD_GPO].alt_func_select != PFS_AF_ZERO
       && !pcr_r[PFS_PAD_GPO].nmi0_sel && !pcr_r[PFS_PAD_GPO].nmi1_sel)
      |-> !pad_oe[PFS_PAD_GPO])
      else $error("gpio-only pad driven by a peripheral code");

   // test-port data in follows its pad while owned
   tap_tdi_in_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (own_r[PFS_PAD_TDI] && $past(rstn, 2))
      |-> (tap_tdi == $past(pad_in[PFS_PAD_TDI], 2)))
      else $error("test port data in lost");

   // test-port mode select follows its pad while owned
   tap_tms_in_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (own_r[PFS_PAD_TMS] && $past(rstn, 2))
      |-> (tap_tms == $past(pad_in[PFS_PAD_TMS], 2)))
      else $error("test port mode select lost");

   // released test-port clock stays low
   tap_release_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      !own_r[PFS_PAD_TCK] |-> !tap_tck)
      else $error("test port clock seen after release");

   // self-test pad not driven once reset is gone
   selftest_quiet_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      (pcr_r[PFS_PAD_TRC] == pfs_pcr_t'(PFS_PCR_RST) && !trc_lo_en)
      |-> !pad_oe[PFS_PAD_TRC])
      else $error("self-test pad driven outside reset");

   // read data only in the cycle after a read strobe
   rd_idle_zero_a : assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(rd_en) |-> (rdata == '0))
      else $error("read data outside its cycle");

endmodule : pfs_top
`default_nettype wire

// >>> src/pfs_pkg.sv
package pfs_pkg;

   localparam int PFS_NPAD   = 24;
   localparam int PFS_NINSEL = 4;
   localparam int PFS_ADDR_W = 10;
   localparam int PFS_DATA_W = 32;
   localparam int PFS_SEL_W  = 5;
   localparam int PFS_NALT   = 4;

   // pad indices of the special pads
   localparam int PFS_PAD_TDI  = 0;
   localparam int PFS_PAD_TDO  = 1;
   localparam int PFS_PAD_TCK  = 2;
   localparam int PFS_PAD_TMS  = 3;
   localparam int PFS_PAD_TRC  = 4;
   localparam int PFS_PAD_MSG  = 16;
   localparam int PFS_PAD_TCLK = 17;
   localparam int PFS_PAD_GPO  = 18;
   localparam int PFS_NGPO     = 3;
   localparam int PFS_NTRC     = 12;
   localparam int PFS_NTRC_LO  = 8;

   // register map, byte addresses
   localparam logic [9:0] PFS_PCR_BASE   = 10'h000;
   localparam logic [9:0] PFS_DOUT_ADDR  = 10'h100;
   localparam logic [9:0] PFS_DIN_ADDR   = 10'h104;
   localparam logic [9:0] PFS_OWN_ADDR   = 10'h108;
   localparam logic [9:0] PFS_INSEL_BASE = 10'h140;

   // reset values
   localparam logic [7:0] PFS_PCR_RST   = 8'h00;
   localparam logic [3:0] PFS_OWN_RST   = 4'hf;
   localparam logic [4:0] PFS_INSEL_RST = 5'h00;

   // alt-function codes
   localparam logic [2:0] PFS_AF_ZERO  = 3'h0;
   localparam logic [2:0] PFS_AF_ONE   = 3'h1;
   localparam logic [2:0] PFS_AF_TWO   = 3'h2;
   localparam logic [2:0] PFS_AF_THREE = 3'h3;
   localparam logic [2:0] PFS_AF_FOUR  = 3'h4;

   typedef struct packed {
      logic       nmi1_sel;
      logic       nmi0_sel;
      logic       pull_up_enable;
      logic       output_buffer_enable;
      logic       input_buffer_enable;
      logic [2:0] alt_func_select;
   } pfs_pcr_t;

   typedef struct packed {
      logic data;
      logic oe;
   } pfs_drv_t;

   typedef struct packed {
      logic trace_clock_enable;
      logic pipeline_status_enable;
      logic full_port_mode;
   } pfs_dbg_t;

   typedef struct packed {
      logic [11:0] trace_data_out;
      logic        trace_msg_start_end;
      logic        trace_clock_out;
   } pfs_trace_t;

endpackage : pfs_pkg

// >>> src/pfs_pad_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pfs_pad_cell
   import pfs_pkg::*;
(
   input  wire pfs_pkg::pfs_pcr_t      cfg,
   input  wire logic                   gpio_only,
   input  wire logic                   gpio_data,
   input  wire pfs_pkg::pfs_drv_t [3:0] alt,
   output logic                        out,
   output logic                        oe
);
   logic [1:0] alt_idx;

   assign alt_idx = 2'(cfg.alt_func_select - PFS_AF_ONE);

   always_comb begin
      out = 1'b0;
      oe  = 1'b0;
      case (cfg.alt_func_select)
         PFS_AF_ZERO: begin
            out = gpio_data;
            oe  = cfg.output_buffer_enable;
         end
         PFS_AF_ONE, PFS_AF_TWO, PFS_AF_THREE, PFS_AF_FOUR: begin
            if (!gpio_only) begin
               out = alt[alt_idx].data;
               oe  = alt[alt_idx].oe;
            end
         end
         default: begin
            out = 1'b0;
            oe  = 1'b0;
         end
      endcase
   end
endmodule : pfs_pad_cell
`default_nettype wire

// >>> bench/pfs_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfs_board_model (
   input  wire logic        rstn,
   input  wire logic        selftest_en,
   input  wire logic [23:0] pad_out,
   input  wire logic [23:0] pad_oe,
   input  wire logic [23:0] ext_lvl,
   output logic      [23:0] pad_in
);
   // board drives every pad the device leaves alone, so no pad floats
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else pad_in[i] = ext_lvl[i];
      end
      // self-test pad never pulled to ground while reset is low and self-test is enabled
      if (!rstn && selftest_en && !pad_oe[4]) pad_in[4] = 1'b1;
   end
endmodule : pfs_board_model
`default_nettype wire

// >>> bench/tb_pad_function_selector.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pad_function_selector;
   import pfs_pkg::*;
   logic                 clk_sys, rstn, wr_en, rd_en, tap_tdo, tap_tdo_oe;
   logic                 tap_tdi, tap_tck, tap_tms, selftest_en, lo, hi;
   logic [9:0]           addr;
   logic [31:0]          wdata, rdata, seed, rv, rd_v;
   logic [23:0]          pad_in, pad_out, pad_oe, pad_pu, ext_lvl, periph_pad_in, dout;
   logic [13:0]          en;
   logic [3:0]           insel_in;
   logic [1:0]           nmi_in;
   pfs_drv_t [23:0][3:0] periph_drv;
   pfs_dbg_t             dbg_ctrl;
   pfs_trace_t           trace;
   pfs_drv_t             e;
   int                   miscompares, n_compared;

   pfs_top #(.NPAD(24), .NINSEL(4)) pfs_top_inst (
      .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pu(pad_pu), .periph_drv(periph_drv), .periph_pad_in(periph_pad_in),
      .insel_in(insel_in), .nmi_in(nmi_in), .tap_tdo(tap_tdo), .tap_tdo_oe(tap_tdo_oe),
      .tap_tdi(tap_tdi), .tap_tck(tap_tck), .tap_tms(tap_tms), .dbg_ctrl(dbg_ctrl),
      .trace(trace), .selftest_en(selftest_en));

   pfs_board_model pfs_board_model_inst (.rstn(rstn), .selftest_en(selftest_en),
      .pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .pad_in(pad_in));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // expected pad drive for a code, with output buffer enable set
   function automatic pfs_drv_t cell_exp(input logic [2:0] c, input logic gonly,
                                         input logic dbit, input pfs_drv_t [3:0] d);
      pfs_drv_t r;
      r = '{data: 1'b0, oe: 1'b0};
      if (c == PFS_AF_ZERO) r = '{data: dbit, oe: 1'b1};
      else if (!gonly && c <= PFS_AF_FOUR) r = d[c - 3'h1];
      return r;
   endfunction : cell_exp

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   task automatic roll();
      seed = lfsr(seed);
      rv = seed;
   endtask : roll

   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end

   initial begin
      seed = 32'hd1f3;
      miscompares = 0;
      n_compared = 0;
      rstn = 1'b0;
      addr = '0;
      wdata = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      ext_lvl = '0;
      periph_drv = '0;
      tap_tdo = 1'b1;
      tap_tdo_oe = 1'b1;
      dbg_ctrl = '0;
      trace = '0;
      selftest_en = 1'b1;
      wait_cyc(4);
      chk("st_drive", {pad_oe[4], pad_out[4]}, 2'b11);
      chk("tdo_rst", pad_oe[1], 1'b1);
      chk("gp_rst", pad_oe[23:18], 6'h00);
      @(posedge clk_sys);
      selftest_en <= 1'b0;
      wait_cyc(1);
      chk("st_off", pad_oe[4], 1'b0);
      @(posedge clk_sys);
      dbg_ctrl <= 3'b010;
      wait_cyc(1);
      chk("claim_rst", pad_oe[15], 1'b1);
      wait_cyc(3);
      @(posedge clk_sys);
      rstn <= 1'b1;
      dbg_ctrl <= '0;
      wait_cyc(2);
      chk("oe_after", pad_oe & 24'hfffffd, 24'h0);
      chk("pu_after", pad_pu, 24'h0);
      rd(PFS_OWN_ADDR, rd_v);
      chk("own_rst", rd_v, 32'hf);
      rd(PFS_PCR_BASE + 10'h054, rd_v);
      chk("pcr_rst", rd_v, 32'h0);
      @(posedge clk_sys);
      ext_lvl <= 24'h00000d;
      tap_tdo <= 1'b0;
      wait_cyc(3);
      chk("tap_in", {tap_tms, tap_tck, tap_tdi}, 3'b111);
      chk("tap_out", {pad_out[1], pad_oe[1]}, 2'b01);
      wr(PFS_OWN_ADDR, 32'h0);
      wait_cyc(1);
      chk("tap_rel", {tap_tms, tap_tck, tap_tdi, pad_oe[1]}, 4'h0);
      wr(PFS_DOUT_ADDR, 32'h0);
      wr(PFS_PCR_BASE + 10'h018, 32'h10); // gpio drive, pull-up left clear
      for (int k = 0; k < 8; k++) begin
         roll();
         @(posedge clk_sys);
         dbg_ctrl <= k[2:0];
         trace <= rv[13:0];
         wait_cyc(1);
         lo = k[2] | k[1];
         hi = (k[2] & k[0]) | k[1];
         en = {{2{lo}}, {4{hi}}, {8{lo}}};
         chk("trc_oe", pad_oe[17:4], en | 14'h0004);
         chk("trc_out", pad_out[17:4] & (en | 14'h0004), {trace.trace_clock_out,
             trace.trace_msg_start_end, trace.trace_data_out} & en);
      end
      @(posedge clk_sys);
      dbg_ctrl <= '0;
      for (int c = 0; c < 8; c++) begin
         roll();
         @(posedge clk_sys);
         periph_drv <= {6{rv}};
         dout = rv[23:0];
         wr(PFS_DOUT_ADDR, {8'h00, dout});
         wr(PFS_PCR_BASE + 10'h054, {29'h2, c[2:0]});
         wr(PFS_PCR_BASE + 10'h048, {29'h2, c[2:0]});
         wait_cyc(1);
         e = cell_exp(c[2:0], 1'b0, dout[21], periph_drv[21]);
         chk("af_pad", {pad_out[21] & e.oe, pad_oe[21]}, {e.data & e.oe, e.oe});
         e = cell_exp(c[2:0], 1'b1, dout[18], periph_drv[18]);
         chk("gpio_pad", {pad_out[18] & e.oe, pad_oe[18]}, {e.data & e.oe, e.oe});
      end
      rd(PFS_PCR_BASE + 10'h054, rd_v);
      chk("pcr_rb", rd_v, 32'h17);
      wait_cyc(1);
      chk("rd_stand", rdata, 32'h0);
      wr(10'h3fc, 32'hffffffff);
      rd(10'h3fc, rd_v);
      chk("unmapped", rd_v, 32'h0);
      @(posedge clk_sys);
      periph_drv <= '0;
      for (int k = 0; k < 4; k++) begin
         roll();
         wr(PFS_PCR_BASE + 10'h058, {28'h0, k[1], rv[2:0]});
         @(posedge clk_sys);
         ext_lvl <= rv[31:8];
         wait_cyc(3);
         chk("ibe_gate", periph_pad_in[22], k[1] & ext_lvl[22]);
      end
      wr(PFS_INSEL_BASE, 32'd22);
      wr(PFS_INSEL_BASE + 10'h004, 32'd31);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         ext_lvl <= {1'b0, k[0], 22'h0};
         wait_cyc(3);
         chk("insel", insel_in[1:0], {1'b0, k[0]});
      end
      @(posedge clk_sys);
      periph_drv <= {96{2'b01}};
      for (int k = 0; k < 4; k++) begin
         wr(PFS_PCR_BASE + 10'h05c, k[1] ? 32'h81 : 32'h41);
         wr(PFS_PCR_BASE + 10'h054, k[1] ? 32'h81 : 32'h41);
         @(posedge clk_sys);
         ext_lvl <= {k[0], 1'b0, k[0], 21'h0};
         wait_cyc(3);
         chk("nmi", {pad_oe[23] | pad_oe[21], nmi_in}, {1'b0, k[1] & k[0], ~k[1] & k[0]});
      end
      summarize();
   end
endmodule : tb_pad_function_selector
`default_nettype wire
